// >>> src/ebs_consts.vh
// Constants for the serial memory write-busy status block
// How it works
// RL1 - Array locked, commands ignored during write
// RL2 - CS low after write command starts cycle
// RL3 - Host waits 10ms or polls DO
// RL4 - CS high: DO low busy, high done
// RL5 - Status valid with no SK edges
// RL6 - DO stays high whenever selected until cleared
// RL7 - Clocked-in start bit clears ready indication
// RL8 - Host may send lone start bit to clear
// RL9 - CS low: DO in high impedance
`ifndef EBS_CONSTS_VH
`define EBS_CONSTS_VH

// Clock rate and self-timed write length
`define EBS_CLK_KHZ    10000
`define EBS_TWR_US     10000
`define EBS_TWR_CYC    ((`EBS_TWR_US * `EBS_CLK_KHZ) / 1000)
`define EBS_TMR_W      17

// Command layout: start bit, two opcode bits, address, data
`define EBS_OP_W       2
`define EBS_ADDR_W     7
`define EBS_DATA_W     8
`define EBS_CNT_W      6

// Opcodes
`define EBS_OP_EXT     2'h0
`define EBS_OP_WRITE   2'h1
`define EBS_OP_READ    2'h2
`define EBS_OP_ERASE   2'h3

// Extended-opcode selectors in the two top address bits
`define EBS_EXT_WRALL  2'h1
`define EBS_EXT_ERALL  2'h2

// Input synchroniser depth
`define EBS_SYNC_N     3

`endif

// >>> src/ebs_sync.v
// Three-stage pin synchroniser with agreement filter
`default_nettype none

module ebs_sync #(
  parameter W = 1
) (
  input  wire         clock,
  input  wire         rstn,
  input  wire [W-1:0] pin_in,
  output reg  [W-1:0] level_out
);

  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;

  // Output follows only when the second and third stages agree
  always @(posedge clock) begin
    if (!rstn) begin
      s1_r      <= {W{1'b0}};
      s2_r      <= {W{1'b0}};
      s3_r      <= {W{1'b0}};
      level_out <= {W{1'b0}};
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      level_out <= ((s2_r ~^ s3_r) & s3_r) | ((s2_r ^ s3_r) & level_out);
    end
  end

endmodule // ebs_sync

`default_nettype wire

// >>> src/ebs_status.v
// Serial memory front end: command capture, self-timed write and ready/busy status on DO
`include "ebs_consts.vh"
`default_nettype none

module ebs_status #(
  parameter ADDR_W    = `EBS_ADDR_W,
  parameter DATA_W    = `EBS_DATA_W,
  parameter TMR_W     = `EBS_TMR_W,
  parameter WR_CYCLES = `EBS_TWR_CYC
) (
  input  wire              clock,
  input  wire              rstn,
  input  wire              cs,
  input  wire              sk,
  input  wire              di,
  output reg               do_out,
  output reg               do_oe,
  output reg               wr_go,
  output reg  [1:0]        wr_op,
  output reg  [ADDR_W-1:0] wr_addr,
  output reg  [DATA_W-1:0] wr_data,
  output reg               wr_busy,
  output reg               array_open
);

  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_SHIFT = 2'h1;
  localparam [1:0] ST_BUSY  = 2'h2;
  localparam [1:0] ST_SKIP  = 2'h3;

  // Counts worked out at full width, then cut to the counter widths
  localparam integer CNT_ADDR_I = `EBS_OP_W;
  localparam integer CNT_DATA_I = `EBS_OP_W + ADDR_W;
  localparam integer CNT_FULL_I = `EBS_OP_W + ADDR_W + DATA_W;
  localparam integer TMR_LAST_I = WR_CYCLES - 1;

  localparam [`EBS_CNT_W-1:0] CNT_ADDR = CNT_ADDR_I[`EBS_CNT_W-1:0];
  localparam [`EBS_CNT_W-1:0] CNT_DATA = CNT_DATA_I[`EBS_CNT_W-1:0];
  localparam [`EBS_CNT_W-1:0] CNT_FULL = CNT_FULL_I[`EBS_CNT_W-1:0];
  localparam [TMR_W-1:0]      TMR_LAST = TMR_LAST_I[TMR_W-1:0];

  wire [2:0] pins_s;
  wire       cs_s;
  wire       sk_s;
  wire       di_s;

  ebs_sync #(
    .W (3)
  ) i_ebs_sync (
    .clock     (clock),
    .rstn      (rstn),
    .pin_in    ({cs, sk, di}),
    .level_out (pins_s)
  );

  assign cs_s = pins_s[2];
  assign sk_s = pins_s[1];
  assign di_s = pins_s[0];

  reg                  cs_q_r;
  reg                  sk_q_r;
  reg [1:0]            st_r;
  reg [1:0]            st_nxt;
  reg [`EBS_CNT_W-1:0] cnt_r;
  reg [1:0]            op_r;
  reg [ADDR_W-1:0]     addr_r;
  reg [DATA_W-1:0]     data_r;
  reg [TMR_W-1:0]      tmr_r;
  reg                  rdy_r;
  reg                  pend_r;

  wire sk_rise = sk_s & ~sk_q_r;
  wire cs_fall = ~cs_s & cs_q_r;
  wire clk_in  = cs_s & sk_rise;
  wire tmr_end = (tmr_r == TMR_LAST);

  // Write-type decode and the number of bits it needs after the start bit
  reg                  is_wr;
  reg [`EBS_CNT_W-1:0] need;
  always @* begin
    is_wr = 1'b0;
    need  = CNT_DATA;
    case (op_r)
      `EBS_OP_WRITE: begin
        is_wr = 1'b1;
        need  = CNT_FULL;
      end
      `EBS_OP_ERASE: begin
        is_wr = 1'b1;
      end
      `EBS_OP_EXT: begin
        if (addr_r[ADDR_W-1 -: 2] == `EBS_EXT_WRALL) begin
          is_wr = 1'b1;
          need  = CNT_FULL;
        end else if (addr_r[ADDR_W-1 -: 2] == `EBS_EXT_ERALL) begin
          is_wr = 1'b1;
        end
      end
      default: begin
        is_wr = 1'b0;
      end
    endcase
  end

  wire cmd_done = is_wr && (cnt_r >= need) && (cnt_r >= CNT_DATA);

  // Frame and write-cycle sequencer
  always @* begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: begin
        if (clk_in && di_s) begin
          st_nxt = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (cs_fall) begin
          st_nxt = cmd_done ? ST_BUSY : ST_IDLE; // [RL2]
        end else if (clk_in && cnt_r == CNT_FULL) begin
          st_nxt = ST_SKIP;
        end
      end
      ST_BUSY: begin
        if (tmr_end) begin
          st_nxt = ST_IDLE; // [RL1]
        end
      end
      ST_SKIP: begin
        if (cs_fall) begin
          st_nxt = cmd_done ? ST_BUSY : ST_IDLE; // [RL2]
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clock) begin
    if (!rstn) begin
      cs_q_r <= 1'b0;
      sk_q_r <= 1'b0;
      st_r   <= ST_IDLE;
      cnt_r  <= {`EBS_CNT_W{1'b0}};
      op_r   <= 2'h0;
      addr_r <= {ADDR_W{1'b0}};
      data_r <= {DATA_W{1'b0}};
      tmr_r  <= {TMR_W{1'b0}};
    end else begin
      cs_q_r <= cs_s;
      sk_q_r <= sk_s;
      st_r   <= st_nxt;
      if (st_r == ST_IDLE) begin
        cnt_r <= {`EBS_CNT_W{1'b0}};
        op_r  <= 2'h0;
      end else if (st_r == ST_SHIFT && clk_in && cnt_r < CNT_FULL) begin
        cnt_r <= cnt_r + 1'b1;
        if (cnt_r < CNT_ADDR) begin
          op_r <= {op_r[0], di_s};
        end else if (cnt_r < CNT_DATA) begin
          addr_r <= {addr_r[ADDR_W-2:0], di_s};
        end else begin
          data_r <= {data_r[DATA_W-2:0], di_s};
        end
      end
      // Self-timed write runs regardless of the pins
      if (st_r == ST_BUSY) begin
        tmr_r <= tmr_end ? {TMR_W{1'b0}} : tmr_r + 1'b1; // [RL1]
      end else begin
        tmr_r <= {TMR_W{1'b0}};
      end
    end
  end

  // Ready indication: set at write end, cleared by a clocked-in start bit
  always @(posedge clock) begin
    if (!rstn) begin
      rdy_r  <= 1'b0;
      pend_r <= 1'b0;
    end else begin
      if (st_r == ST_BUSY && tmr_end) begin
        rdy_r <= 1'b1; // [RL6]
      end else if (st_r == ST_IDLE && clk_in && di_s) begin
        rdy_r <= 1'b0; // [RL7]
      end
      if (st_nxt == ST_BUSY && st_r != ST_BUSY) begin
        pend_r <= 1'b1;
      end else if (st_r == ST_IDLE && clk_in && di_s) begin
        pend_r <= 1'b0; // [RL7]
      end
    end
  end

  // Array-side write request and lockout
  always @(posedge clock) begin
    if (!rstn) begin
      wr_go      <= 1'b0;
      wr_op      <= 2'h0;
      wr_addr    <= {ADDR_W{1'b0}};
      wr_data    <= {DATA_W{1'b0}};
      wr_busy    <= 1'b0;
      array_open <= 1'b1;
    end else begin
      wr_go <= 1'b0;
      if (st_nxt == ST_BUSY && st_r != ST_BUSY) begin
        wr_go   <= 1'b1; // [RL2]
        wr_op   <= op_r;
        wr_addr <= addr_r;
        wr_data <= data_r;
      end
      wr_busy    <= (st_nxt == ST_BUSY);
      array_open <= (st_nxt != ST_BUSY); // [RL1]
    end
  end

  // Status on DO follows CS while a write is pending or ready; SK plays no part
  always @(posedge clock) begin
    if (!rstn) begin
      do_out <= 1'b0;
      do_oe  <= 1'b0;
    end else begin
      if (cs_s && (pend_r || rdy_r)) begin
        do_oe  <= 1'b1; // [RL5]
        do_out <= rdy_r && st_r != ST_BUSY; // [RL4] [RL6]
      end else begin
        do_oe  <= 1'b0; // [RL9]
        do_out <= 1'b0;
      end
    end
  end

endmodule // ebs_status

`default_nettype wire

// >>> tb/ebs_status_assertions.sv
// Checker for the write-busy status block
`default_nettype none
module ebs_status_assertions (
  input wire logic clock,
  input wire logic rstn,
  input wire logic cs,
  input wire logic do_out,
  input wire logic do_oe,
  input wire logic wr_go,
  input wire logic wr_busy,
  input wire logic array_open
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence s_sel; cs[*7]; endsequence
  sequence s_desel; !cs[*7]; endsequence
  property p_lock; wr_busy |-> !array_open; endproperty
  a_lock: assert property (p_lock) else $error("array open in write");
  property p_keep; s_sel ##0 $fell(do_oe) |-> !$past(wr_busy); endproperty
  a_keep: assert property (p_keep) else $error("status lost in write");
  property p_go; wr_go |=> wr_busy; endproperty
  a_go: assert property (p_go) else $error("start without busy");
  property p_busy; s_sel ##0 wr_busy |-> do_oe && !do_out; endproperty
  a_busy: assert property (p_busy) else $error("busy not shown");
  property p_done; $fell(wr_busy) && do_oe |-> ##[1:2] do_out; endproperty
  a_done: assert property (p_done) else $error("ready not shown");
  property p_hiz; s_desel |-> !do_oe; endproperty
  a_hiz: assert property (p_hiz) else $error("output driven");
  property p_once; wr_busy |=> !wr_go; endproperty
  a_once: assert property (p_once) else $error("second start in write");
endmodule // ebs_status_assertions
bind ebs_status ebs_status_assertions i_chk (.clock(clock), .rstn(rstn), .cs(cs),
  .do_out(do_out), .do_oe(do_oe), .wr_go(wr_go), .wr_busy(wr_busy),
  .array_open(array_open));
`default_nettype wire

// >>> tb/ebs_host.sv
// Host model driving the serial memory pins
`default_nettype none
module ebs_host (
  input  wire logic clock,
  output var  logic cs,
  output var  logic sk,
  output var  logic di
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cs = 1'h0;
    sk = 1'h0;
    di = 1'h0;
  end
  // Select change with no SK edges, then settle past the status delay
  task automatic pin(input logic v);
    @(posedge clock) cs <= v;
    repeat (8) @(posedge clock);
    @(negedge clock);
  endtask
  // MSB first, eight clocks per SK period
  task automatic send(input logic [17:0] v, input int n);
    pin(1'h1);
    for (int i = 17; i > 17 - n; i--) begin
      @(posedge clock);
      sk <= 1'h0;
      di <= v[i];
      repeat (3) @(posedge clock);
      @(posedge clock) sk <= 1'h1;
      repeat (3) @(posedge clock);
    end
    @(posedge clock);
    sk <= 1'h0;
    di <= 1'h0;
    repeat (3) @(posedge clock);
    pin(1'h0);
  endtask
endmodule // ebs_host
`default_nettype wire

// >>> tb/test_ebs_status.sv
// Testbench for the write-busy status block
`default_nettype none
module test_ebs_status;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WR = 400;
  localparam logic [17:0] CMD [4] = '{18'h2D5A3, 18'h3AA00, 18'h2205C, 18'h24000};
  localparam int LEN [4] = '{18, 10, 18, 10};
  localparam logic [1:0] OP [4] = '{2'h1, 2'h3, 2'h0, 2'h0};
  logic clock;
  logic rstn;
  logic cs, sk, di, do_out, do_oe, wr_go, wr_busy, array_open;
  logic [1:0] wr_op;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  int err_count = 0;
  int checks_done = 0;
  int go_cnt = 0;
  int cyc_cnt = 0;
  initial begin
    clock = 1'h0;
    forever #50 clock = ~clock;
  end
  ebs_host i_ebs_host (.clock(clock), .cs(cs), .sk(sk), .di(di));
  ebs_status #(.WR_CYCLES(WR)) i_ebs_status (.clock(clock), .rstn(rstn), .cs(cs),
    .sk(sk), .di(di), .do_out(do_out), .do_oe(do_oe), .wr_go(wr_go), .wr_op(wr_op),
    .wr_addr(wr_addr), .wr_data(wr_data), .wr_busy(wr_busy), .array_open(array_open));
  always @(posedge clock) begin
    cyc_cnt <= cyc_cnt + 1;
    if (wr_go === 1'h1)
      go_cnt <= go_cnt + 1;
    if (cyc_cnt == 6000) begin
      err_count++;
      test_done();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Holds select high and samples DO with SK idle
  task automatic poll();
    int n = 0;
    while (!(do_oe === 1'h1 && do_out === 1'h1) && n < WR + 20) begin
      @(negedge clock);
      n++;
    end
    chk({do_oe, do_out, wr_busy, array_open}, 4'hD);
  endtask
  task automatic t_busy();
    i_ebs_host.send(CMD[0], 18);
    i_ebs_host.send(CMD[2], 18);
    chk(8'(go_cnt), 8'h1);
    chk({wr_addr, wr_busy}, {7'h55, 1'h1});
    chk(wr_data, 8'hA3);
    i_ebs_host.pin(1'h1);
    poll();
  endtask
  task automatic t_cmds();
    for (int i = 0; i < 4; i++) begin
      i_ebs_host.send(CMD[i], LEN[i]);
      chk(8'(go_cnt), 8'(i + 2));
      chk({wr_op, wr_busy, array_open, do_oe}, {OP[i], 3'h4});
      i_ebs_host.pin(1'h1);
      chk({do_oe, do_out}, 2'h2);
      poll();
      i_ebs_host.pin(1'h0);
      chk(do_oe, 1'h0);
      i_ebs_host.pin(1'h1);
      chk({do_oe, do_out}, 2'h3);
      i_ebs_host.send(18'h20000, 1);
      i_ebs_host.pin(1'h1);
      chk(do_oe, 1'h0);
    end
  endtask
  // Fixed wait instead of polling, then a lone start bit
  task automatic t_wait();
    i_ebs_host.send(CMD[1], LEN[1]);
    repeat (WR + 10) @(negedge clock);
    i_ebs_host.pin(1'h1);
    chk({do_oe, do_out, wr_busy, array_open}, 4'hD);
    chk(8'(go_cnt), 8'h6);
    i_ebs_host.send(18'h20000, 1);
  endtask
  // Read, enable and a cut write frame start nothing
  task automatic t_refuse();
    i_ebs_host.send(18'h30000, 10);
    chk(8'(go_cnt), 8'h6);
    i_ebs_host.send(18'h26000, 10);
    chk(8'(go_cnt), 8'h6);
    i_ebs_host.send(CMD[0], 14);
    chk(8'(go_cnt), 8'h6);
    i_ebs_host.pin(1'h1);
    chk({do_oe, wr_busy, array_open}, 3'h1);
  endtask
  task automatic test_done();
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    rstn = 1'h0;
    repeat (20) @(posedge clock);
    rstn <= 1'h1;
    t_busy();
    t_cmds();
    t_wait();
    t_refuse();
    test_done();
  end
endmodule // test_ebs_status
`default_nettype wire
